// File: pic_pkg.sv
// Shared constants for the prioritized interrupt controller.
// Contract
// - Bit 15 reads non-maskable pin level, read-only.
// - Reset initializes control register; standby keeps it.
// - Bits 14..9 read zero; software writes zero.
// - Bit 8 picks non-maskable edge: 0 falling.
// - Bits 7..0 pick pin sense: 0 low-level.
// - Highest programmed level among pending requests wins.
// - Equal levels resolved by fixed default order.
// - Forward only when level strictly exceeds mask.
// - Accepted request drives request pin low.
// - Request pin mirrors the CPU request line.
// - Level request releases pin after mask update.
// - Edge request releases pin on exception start.
// - Pin stays low for newer higher request.
// - Edge request pends once, edges do not queue.
// - Level request vanishes if pin released early.
// - On-chip module requests are level requests.
// - Four-bit priority fields, 0 lowest, 15 highest.
// - Reset clears priority fields; standby keeps them.
package pic_pkg;
  localparam int PIC_N_IRQ = 8;
  localparam int PIC_N_MOD = 11;
  localparam int PIC_N_SRC = PIC_N_IRQ + PIC_N_MOD;
  localparam int PIC_IDX_W = 5;
  localparam int PIC_N_PRI = 5;
  localparam logic [7:0] PIC_OFS_CTRL = 8'h00;
  localparam logic [7:0] PIC_OFS_PRI = 8'h04;
  localparam logic [7:0] PIC_OFS_PRI_END = 8'h14;
  localparam logic [7:0] PIC_OFS_STAT = 8'h18;
  localparam int PIC_NONMASKABLE_PIN_LEVEL_BIT = 15;
  localparam int PIC_NONMASKABLE_EDGE_SELECT_BIT = 8;
  localparam int PIC_SENSE_MSB = 7;
  localparam int PIC_ST_NMI_BIT = 8;
  localparam int PIC_ST_REQ_BIT = 9;
  localparam int PIC_ST_LVL_LSB = 12;
  localparam int PIC_ST_VEC_LSB = 16;
  localparam logic [8:0] PIC_CTRL_RST = 9'h000;
  localparam logic [15:0] PIC_PRI_RST = 16'h0000;
  localparam logic [4:0] PIC_NMI_VEC = 5'h1F;
  localparam logic [3:0] PIC_NMI_LVL = 4'hF;
  localparam logic [2:0] PIC_HSIZE_WORD = 3'h2;
endpackage

// File: pic_arb_if.sv
// Connection between the controller top and its priority arbiter.
`timescale 1ns/1ps
interface pic_arb_if;
  import pic_pkg::*;
  logic [PIC_N_SRC-1:0] req;
  logic [4*PIC_N_SRC-1:0] lvl;
  logic found;
  logic [PIC_IDX_W-1:0] idx;
  logic [3:0] top_lvl;
  modport ctl (output req, lvl, input found, idx, top_lvl);
  modport arb (input req, lvl, output found, idx, top_lvl);
endinterface

// File: pic_arbiter.sv
// Priority arbiter: picks the highest level, lowest index on ties.
`timescale 1ns/1ps
module pic_arbiter
  import pic_pkg::*;
(
  pic_arb_if.arb arb_io // Requests and levels in, winner out.
);

  // Scan from the last source down so that an equal level lets the lower index win.
  always_comb begin
    arb_io.found = 1'b0;
    arb_io.idx = '0;
    arb_io.top_lvl = '0;
    for (int i = PIC_N_SRC - 1; i >= 0; i--) begin
      if (arb_io.req[i] && (!arb_io.found || arb_io.lvl[4*i +: 4] >= arb_io.top_lvl)) begin
        arb_io.found = 1'b1;
        arb_io.idx = PIC_IDX_W'(i);
        arb_io.top_lvl = arb_io.lvl[4*i +: 4];
      end
    end
  end

endmodule

// File: pic_top.sv
// Interrupt controller top: AHB-Lite registers, pin sensing, mask compare.
`timescale 1ns/1ps
module pic_top
  import pic_pkg::*;
(
  input wire logic clock_in, // System clock, 20 MHz.
  input wire logic sys_rst_in, // Synchronous reset, active high.
  input wire logic hsel_in, // AHB slave select.
  input wire logic [7:0] haddr_in, // AHB byte address.
  input wire logic [1:0] htrans_in, // AHB transfer type.
  input wire logic hwrite_in, // AHB write strobe.
  input wire logic [2:0] hsize_in, // AHB transfer size.
  input wire logic hready_in, // AHB bus ready.
  input wire logic [31:0] hwdata_in, // AHB write data.
  output logic [31:0] hrdata_out, // AHB read data.
  output logic hreadyout_out, // AHB slave ready.
  output logic hresp_out, // AHB response, always OKAY.
  input wire logic nmi_pin_in, // Non-maskable request pin.
  input wire logic [PIC_N_IRQ-1:0] irq_pin_n_in, // External request pins, low active.
  input wire logic [PIC_N_MOD-1:0] module_req_in, // On-chip module request levels.
  input wire logic [3:0] cpu_mask_level_in, // CPU current mask level.
  input wire logic cpu_accept_in, // CPU starts exception handling.
  output logic cpu_req_out, // Request line to the CPU.
  output logic [PIC_IDX_W-1:0] cpu_vector_out, // Source of the forwarded request.
  output logic [3:0] cpu_level_out, // Level of the forwarded request.
  output logic request_out_pin_n_out // Request mirror pin, low active.
);

  pic_arb_if arb ();

  pic_arbiter u_arb (
    .arb_io(arb)
  );

  // Synchroniser stages and the delayed copy used for edge detection.
  logic nmi_s1_r;
  logic nmi_s2_r;
  logic nmi_d_r;
  logic [PIC_N_IRQ-1:0] irq_s1_r;
  logic [PIC_N_IRQ-1:0] irq_s2_r;
  logic [PIC_N_IRQ-1:0] irq_d_r;

  // Register state.
  logic [PIC_NONMASKABLE_EDGE_SELECT_BIT:0] ctrl_r;
  logic [15:0] pri_r [PIC_N_PRI];

  // Request state.
  logic nmi_pend_r;
  logic [PIC_N_IRQ-1:0] edge_r;
  logic req_r;
  logic [PIC_IDX_W-1:0] vec_r;
  logic [3:0] lvl_r;

  // Bus data phase state.
  logic dp_rd_r;
  logic dp_wr_r;
  logic [7:0] dp_addr_r;
  logic rd_done_r;
  logic [31:0] hrdata_r;

  // Combinational helpers.
  logic take_w;
  logic [PIC_N_IRQ-1:0] sense_w;
  logic [PIC_N_IRQ-1:0] irq_req_w;
  logic [PIC_N_IRQ-1:0] edge_set_w;
  logic [PIC_N_IRQ-1:0] edge_clr_w;
  logic nmi_set_w;
  logic ack_irq_w;
  logic ack_nmi_w;
  logic fwd_w;
  logic [31:0] rd_w;

  // Decodes a byte address as one of the five priority words.
  function automatic logic is_pri(input logic [7:0] a);
    is_pri = (a >= PIC_OFS_PRI) && (a <= PIC_OFS_PRI_END);
  endfunction

  // Turns a priority word address into its array index.
  function automatic logic [2:0] pri_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - PIC_OFS_PRI;
    pri_idx = d[4:2];
  endfunction

  // Pins idle high, so the stages reset high to avoid a false edge at release.
  // pins synchronised first
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      nmi_s1_r <= 1'b1;
      nmi_s2_r <= 1'b1;
      nmi_d_r <= 1'b1;
      irq_s1_r <= '1;
      irq_s2_r <= '1;
      irq_d_r <= '1;
    end else begin
      nmi_s1_r <= nmi_pin_in;
      nmi_s2_r <= nmi_s1_r;
      nmi_d_r <= nmi_s2_r;
      irq_s1_r <= irq_pin_n_in;
      irq_s2_r <= irq_s1_r;
      irq_d_r <= irq_s2_r;
    end
  end

  // Control bit 7 serves pin 0, bit 0 serves pin 7, so the order is reversed here.
  for (genvar i = 0; i < PIC_N_IRQ; i++) begin : g_pin
    assign sense_w[i] = ctrl_r[PIC_SENSE_MSB - i];
    assign irq_req_w[i] = sense_w[i] ? edge_r[i] : !irq_s2_r[i];
  end

  // Each source takes its nibble; bits 15..12 of a word serve the first source.
  for (genvar f = 0; f < PIC_N_SRC; f++) begin : g_lvl
    assign arb.lvl[4*f +: 4] = pri_r[f/4][4*(3 - f%4) +: 4];
  end

  // External pins first, then on-chip modules, which fixes the default order.
  // module level requests
  assign arb.req = {module_req_in, irq_req_w};

  // Edges only count while the pin is in edge mode.
  assign edge_set_w = sense_w & irq_d_r & ~irq_s2_r;

  assign nmi_set_w = ctrl_r[PIC_NONMASKABLE_EDGE_SELECT_BIT] ? (nmi_s2_r & ~nmi_d_r) : (~nmi_s2_r & nmi_d_r);

  // The CPU acknowledges whatever source is currently on the vector output.
  assign ack_nmi_w = cpu_accept_in && (vec_r == PIC_NMI_VEC);
  assign ack_irq_w = cpu_accept_in && (vec_r < PIC_IDX_W'(PIC_N_IRQ));
  assign edge_clr_w = ack_irq_w ? (PIC_N_IRQ'(1) << vec_r[2:0]) : '0;

  // An edge latch holds one event; a set in the clearing cycle wins.
  // single pending edge
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      edge_r <= '0;
    end else begin
      edge_r <= ((edge_r & ~edge_clr_w) | edge_set_w) & sense_w;
    end
  end

  // The non-maskable latch is cleared only when the CPU takes that source.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      nmi_pend_r <= 1'b0;
    end else begin
      nmi_pend_r <= nmi_set_w | (nmi_pend_r & ~ack_nmi_w);
    end
  end

  // Non-maskable requests bypass the mask; others need a strictly higher level.
  // strict mask compare
  assign fwd_w = nmi_pend_r || (arb.found && (arb.top_lvl > cpu_mask_level_in));

  // The request drops by itself once the mask catches up or the edge is taken.
  // level release on mask
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      req_r <= 1'b0;
      vec_r <= '0;
      lvl_r <= '0;
    end else begin
      req_r <= fwd_w;
      if (fwd_w) begin
        vec_r <= nmi_pend_r ? PIC_NMI_VEC : arb.idx;
        lvl_r <= nmi_pend_r ? PIC_NMI_LVL : arb.top_lvl;
      end
    end
  end

  // The pin and the CPU line come from the same flip-flop, so they never skew.
  // pin driven low
  assign request_out_pin_n_out = !req_r;
  assign cpu_req_out = req_r;
  assign cpu_vector_out = vec_r;
  assign cpu_level_out = lvl_r;

  // Only whole-word transfers are taken; other sizes are ignored and answer OKAY.
  assign take_w = hsel_in && htrans_in[1] && hready_in && (hsize_in == PIC_HSIZE_WORD);

  // Address phase capture.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      dp_rd_r <= 1'b0;
      dp_wr_r <= 1'b0;
      dp_addr_r <= 8'h00;
    end else if (hready_in) begin
      dp_rd_r <= take_w && !hwrite_in;
      dp_wr_r <= take_w && hwrite_in;
      dp_addr_r <= {haddr_in[7:2], 2'b00};
    end
  end

  // Reads take one wait state so that hrdata comes from a flip-flop.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rd_done_r <= 1'b0;
      hrdata_r <= 32'h0000_0000;
    end else begin
      rd_done_r <= dp_rd_r && !rd_done_r;
      if (dp_rd_r && !rd_done_r) begin
        hrdata_r <= rd_w;
      end
    end
  end

  assign hreadyout_out = !(dp_rd_r && !rd_done_r);
  assign hresp_out = 1'b0;
  assign hrdata_out = hrdata_r;

  // Read multiplexer; unmapped addresses and reserved bits read as zero.
  always_comb begin
    rd_w = 32'h0000_0000;
    if (dp_addr_r == PIC_OFS_CTRL) begin
      rd_w[PIC_NONMASKABLE_PIN_LEVEL_BIT] = nmi_s2_r;
      rd_w[PIC_NONMASKABLE_EDGE_SELECT_BIT:0] = ctrl_r;
    end else if (is_pri(dp_addr_r)) begin
      rd_w[15:0] = pri_r[pri_idx(dp_addr_r)];
    end else if (dp_addr_r == PIC_OFS_STAT) begin
      rd_w[PIC_N_IRQ-1:0] = irq_req_w;
      rd_w[PIC_ST_NMI_BIT] = nmi_pend_r;
      rd_w[PIC_ST_REQ_BIT] = req_r;
      rd_w[PIC_ST_LVL_LSB +: 4] = lvl_r;
      rd_w[PIC_ST_VEC_LSB +: PIC_IDX_W] = vec_r;
    end
  end

  // Writes land in the data phase; the level bit and reserved bits are dropped.
  // There is no standby input: only reset initializes these registers.
  // reset only
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ctrl_r <= PIC_CTRL_RST;
      for (int k = 0; k < PIC_N_PRI; k++) begin
        pri_r[k] <= PIC_PRI_RST;
      end
    end else if (dp_wr_r) begin
      if (dp_addr_r == PIC_OFS_CTRL) begin
        ctrl_r <= hwdata_in[PIC_NONMASKABLE_EDGE_SELECT_BIT:0];
      end
      if (is_pri(dp_addr_r)) begin
        pri_r[pri_idx(dp_addr_r)] <= hwdata_in[15:0];
      end
    end
  end

  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  // Control read shows the pin level and zero reserved bits.
  a_ctrl_read_bits: assert property (
    (dp_rd_r && !rd_done_r && dp_addr_r == PIC_OFS_CTRL) |=>
      (hrdata_out[14:9] == 6'h00) && (hrdata_out[PIC_NONMASKABLE_PIN_LEVEL_BIT] == $past(nmi_s2_r)))
    else $error("control read shows wrong level or reserved bits");

  // Reset puts control and the first priority word to their initial values.
  a_reset_init: assert property (
    disable iff (1'b0) sys_rst_in |=> (ctrl_r == PIC_CTRL_RST) && (pri_r[0] == PIC_PRI_RST))
    else $error("reset did not clear the registers");

  // A falling pin edge in falling mode sets the latch.
  a_nmi_fall_edge: assert property (
    (!ctrl_r[PIC_NONMASKABLE_EDGE_SELECT_BIT] && nmi_d_r && !nmi_s2_r) |=> nmi_pend_r)
    else $error("falling edge not latched");

  // A rising pin edge in falling mode alone does not set the latch.
  a_nmi_rise_quiet: assert property (
    (!ctrl_r[PIC_NONMASKABLE_EDGE_SELECT_BIT] && !nmi_d_r && nmi_s2_r && !nmi_pend_r) |=> !nmi_pend_r)
    else $error("rising edge latched in falling mode");

  // Level mode follows pin 0 directly.
  a_level_follow: assert property (
    !ctrl_r[PIC_SENSE_MSB] |-> (irq_req_w[0] == !irq_s2_r[0]))
    else $error("level request does not follow pin");

  // A pending edge stays until the CPU takes it.
  a_edge_hold: assert property (
    (edge_r[0] && sense_w[0] && !edge_clr_w[0]) ##1 sense_w[0] |-> edge_r[0])
    else $error("edge request lost before acceptance");

  // Acceptance of an edge source clears its latch when no new edge comes.
  a_edge_ack_clr: assert property (
    (edge_clr_w[0] && !edge_set_w[0]) |=> !edge_r[0])
    else $error("accepted edge still pending");

  // Requests at or below the mask never reach the pin.
  a_mask_block: assert property (
    (!nmi_pend_r && !(arb.found && arb.top_lvl > cpu_mask_level_in)) |=> request_out_pin_n_out)
    else $error("masked request forwarded");

  // A request above the mask drives the pin low next cycle with its level.
  a_fwd_level: assert property (
    (!nmi_pend_r && arb.found && arb.top_lvl > cpu_mask_level_in) |=>
      (!request_out_pin_n_out && cpu_level_out == $past(arb.top_lvl)))
    else $error("request above mask not forwarded");

  // The winner is a pending source with the top level.
  a_win_top: assert property (
    arb.found |-> (arb.req[arb.idx] && arb.lvl[4*arb.idx +: 4] == arb.top_lvl))
    else $error("arbiter winner not pending at top level");

  // A rising pin edge in rising mode sets the latch.
  a_nmi_rise_edge: assert property (
    (ctrl_r[PIC_NONMASKABLE_EDGE_SELECT_BIT] && !nmi_d_r && nmi_s2_r) |=> nmi_pend_r)
    else $error("rising edge not latched");

  // A pending non-maskable request reaches the CPU whatever the mask holds.
  a_nmi_bypass: assert property (
    nmi_pend_r |=> (cpu_req_out && cpu_vector_out == PIC_NMI_VEC && cpu_level_out == PIC_NMI_LVL))
    else $error("non-maskable request not forwarded");

  // While a forwarded request is replaced by a higher one the pin stays low.
  a_higher_hold: assert property (
    (req_r && fwd_w) |=> !request_out_pin_n_out)
    else $error("request pin released under a higher request");

  // A read data phase holds the bus for exactly one wait state.
  a_read_one_wait: assert property (
    (dp_rd_r && !rd_done_r) |=> hreadyout_out)
    else $error("read wait state too long");

  // A control write stores the writable field from the data phase.
  a_ctrl_write: assert property (
    (dp_wr_r && dp_addr_r == PIC_OFS_CTRL) |=> (ctrl_r == $past(hwdata_in[PIC_NONMASKABLE_EDGE_SELECT_BIT:0])))
    else $error("control write lost");

  // A write to the first priority word lands whole.
  a_pri_write: assert property (
    (dp_wr_r && dp_addr_r == PIC_OFS_PRI) |=> (pri_r[0] == $past(hwdata_in[15:0])))
    else $error("priority write lost");

  // A detected edge on pin 0 always leaves the latch set.
  a_edge_set: assert property (
    edge_set_w[0] |=> edge_r[0])
    else $error("pin edge not latched");

  // A module request always takes part, so the winner is at least as high.
  a_module_req: assert property (
    module_req_in[0] |-> (arb.found && arb.top_lvl >= arb.lvl[4*PIC_N_IRQ +: 4]))
    else $error("module request ignored by arbitration");

endmodule

// File: pic_cpu_model.sv
// Behavioural processor core that takes requests from the interrupt controller.
`timescale 1ns/1ps
module pic_cpu_model (
  input wire logic clock_in, // System clock.
  input wire logic sys_rst_in, // Synchronous reset, active high.
  input wire logic req_in, // Request from the controller.
  input wire logic [3:0] level_in, // Level of that request.
  input wire logic [7:0] delay_in, // Cycles before a request is taken.
  input wire logic [7:0] hold_in, // Handler length in cycles.
  input wire logic [3:0] base_mask_in, // Mask level outside handlers.
  output logic accept_out, // Exception start pulse.
  output logic [3:0] mask_out // Current mask level.
);
  logic [7:0] wait_r;
  logic [7:0] hold_r;
  // sample, stack, vector
  // A taken request stands for decode, the two pushes and the vector fetch.
  // Just after a take the core is busy and blind, so one request is never taken twice.
  always_ff @(posedge clock_in) begin
    accept_out <= 1'b0;
    if (sys_rst_in || !req_in || accept_out || (hold_r != 8'h00 && hold_r < 8'h05)) begin
      wait_r <= 8'h00;
    end else if (wait_r >= delay_in) begin
      accept_out <= 1'b1;
      wait_r <= 8'h00;
    end else begin
      wait_r <= wait_r + 8'h01;
    end
  end
  // mask takes level
  // The mask returns to the base level when the handler ends, also after nesting.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      hold_r <= 8'h00;
      mask_out <= base_mask_in;
    end else if (accept_out) begin
      hold_r <= 8'h01;
      mask_out <= level_in;
    end else if (hold_r == 8'h00) begin
      mask_out <= base_mask_in;
    end else if (hold_r >= hold_in) begin
      hold_r <= 8'h00;
    end else begin
      hold_r <= hold_r + 8'h01;
    end
  end
endmodule

// File: pic_testbench.sv
// Self-checking bench for the interrupt controller with a core model.
`timescale 1ns/1ps
module testbench;
  import pic_pkg::*;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready, hresp, accept, req, pin_n, nmi = 1'b1, rd_dp = 1'b0, cpu_chk = 1'b0;
  logic [7:0] irq_n = 8'hFF, delay = 8'h00;
  logic [PIC_N_MOD-1:0] modreq = '0;
  logic [3:0] mask, lvl, base = 4'h0;
  logic [4:0] vec;
  logic [10:0] e, s;
  logic [31:0] d;
  logic [31:0] rd_q[$];
  logic [10:0] cpu_q[$];
  int miscompares = 0, comparisons = 0, cycles = 0;
  integer seed = 32'hE30F13A5;
  pic_top uut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(PIC_HSIZE_WORD), .hready_in(hready),
    .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .nmi_pin_in(nmi), .irq_pin_n_in(irq_n), .module_req_in(modreq), .cpu_mask_level_in(mask),
    .cpu_accept_in(accept), .cpu_req_out(req), .cpu_vector_out(vec), .cpu_level_out(lvl),
    .request_out_pin_n_out(pin_n));
  pic_cpu_model core (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .req_in(req),
    .level_in(lvl), .delay_in(delay), .hold_in(8'h28), .base_mask_in(base),
    .accept_out(accept), .mask_out(mask));
  // Free-running system clock, 50 ns period.
  always #25 clock_in = ~clock_in;
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task results();
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // One single word transfer; the address and data phases wait for ready.
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock_in);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clock_in); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rd_dp <= !wr;
    do @(posedge clock_in); while (hready !== 1'b1);
    rd_dp <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    rd_q.push_back(x);
    ahb(1'b0, a, 32'h0);
  endtask
  // Vector and level are only meaningful while a request stands.
  task cpu(input logic rq, input logic [4:0] v, input logic [3:0] l);
    @(posedge clock_in);
    cpu_q.push_back({rq, !rq, v, l});
    cpu_chk <= 1'b1;
    @(posedge clock_in);
    cpu_chk <= 1'b0;
  endtask
  task wait_for(input int which, input logic v);
    for (int i = 0; i < 80 && ((which == 1) ? accept : req) !== v; i++) @(posedge clock_in);
  endtask
  // Watcher: each result is compared with the oldest note of its kind.
  always @(posedge clock_in) begin
    if (rd_dp && hready === 1'b1) check(hrdata, rd_q.pop_front()); // readback.
    if (rd_dp && hready === 1'b1) check({31'h0, hresp}, 32'h0); // response always OKAY.
    if (cpu_chk) begin
      e = cpu_q.pop_front();
      s = e[10] ? {req, pin_n, vec, lvl} : {req, pin_n, e[8:0]};
      check({21'h0, s}, {21'h0, e}); // request and mirror.
    end
  end
  // A hang ends the run as a failure.
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    tick(10);
    sys_rst_in <= 1'b0;
    rd(PIC_OFS_CTRL, 32'h00008000); // reset value.
    for (int i = 0; i < PIC_N_PRI; i++) rd(PIC_OFS_PRI + 8'(4 * i), 32'h0); // cleared.
    rd(8'h1C, 32'h0); // unmapped reads zero.
    repeat (6) begin
      d = $random(seed);
      nmi <= d[20];
      ahb(1'b1, PIC_OFS_CTRL, {16'h0, d[15], 6'h00, d[8:0]});
      rd(PIC_OFS_CTRL, {16'h0, d[20], 6'h00, d[8:0]}); // fields.
      ahb(1'b1, PIC_OFS_PRI + 8'(4 * (d[2:0] % 5)), {16'h0, d[31:16]});
      rd(PIC_OFS_PRI + 8'(4 * (d[2:0] % 5)), {16'h0, d[31:16]}); // priority field.
    end
    nmi <= 1'b1;
    tick(60);
    for (int i = 0; i < PIC_N_PRI; i++) ahb(1'b1, PIC_OFS_PRI + 8'(4 * i), 32'h0);
    ahb(1'b1, PIC_OFS_CTRL, 32'h0);
    // Level pin 0 at level 5 against mask 5, then mask 4.
    delay <= 8'h14;
    base <= 4'h5;
    ahb(1'b1, PIC_OFS_PRI, 32'h00005300);
    irq_n <= 8'hFE;
    tick(8);
    cpu(1'b0, 5'h00, 4'h0); // equal level ignored.
    base <= 4'h4;
    wait_for(0, 1'b1);
    cpu(1'b1, 5'h00, 4'h5); // forwarded.
    rd(PIC_OFS_STAT, 32'h00005201); // status shows the forwarded request.
    wait_for(0, 1'b0);
    cpu(1'b0, 5'h00, 4'h0); // released after mask update.
    irq_n <= 8'hFF;
    tick(50);
    // Level pin 1 withdrawn before it is taken.
    base <= 4'h0;
    delay <= 8'h28;
    irq_n <= 8'hFD;
    wait_for(0, 1'b1);
    cpu(1'b1, 5'h01, 4'h3); // pending while low.
    irq_n <= 8'hFF;
    tick(50);
    cpu(1'b0, 5'h00, 4'h0); // withdrawn request gone.
    // Tie between pins 4 and 5, then a higher module request.
    ahb(1'b1, PIC_OFS_PRI + 8'h04, 32'h00006600);
    ahb(1'b1, PIC_OFS_PRI + 8'h08, 32'h00009000);
    irq_n <= 8'hCF;
    wait_for(0, 1'b1);
    cpu(1'b1, 5'h04, 4'h6); // fixed order on tie.
    modreq <= 11'h001;
    tick(4);
    cpu(1'b1, 5'h08, 4'h9); // higher level wins.
    wait_for(1, 1'b1);
    irq_n <= 8'hFF;
    tick(50);
    wait_for(0, 1'b1);
    cpu(1'b1, 5'h08, 4'h9); // persists until cleared.
    modreq <= 11'h000;
    tick(80);
    // Edge pin 0: repeated falls, then the pin stays low.
    ahb(1'b1, PIC_OFS_CTRL, 32'h00000080);
    ahb(1'b1, PIC_OFS_PRI + 8'h08, 32'h00000900);
    delay <= 8'h20;
    repeat (2) begin
      irq_n <= 8'hFE;
      tick(3);
      irq_n <= 8'hFF;
      tick(3);
    end
    irq_n <= 8'hFE;
    wait_for(0, 1'b1);
    cpu(1'b1, 5'h00, 4'h5); // falling edge pending.
    wait_for(0, 1'b0);
    cpu(1'b0, 5'h00, 4'h0); // released at exception start.
    tick(60);
    cpu(1'b0, 5'h00, 4'h0); // edges did not queue.
    irq_n <= 8'hFF;
    tick(4);
    irq_n <= 8'hFE;
    wait_for(1, 1'b1);
    modreq <= 11'h002;
    tick(6);
    cpu(1'b1, 5'h09, 4'h9); // higher request keeps pin low.
    modreq <= 11'h000;
    irq_n <= 8'hFF;
    tick(80);
    // Non-maskable input on either selected edge, all levels masked.
    base <= 4'hF;
    delay <= 8'h0A;
    for (int k = 0; k < 2; k++) begin
      ahb(1'b1, PIC_OFS_CTRL, {23'h0, k[0], 8'h00});
      nmi <= k[0];
      wait_for(0, 1'b1);
      cpu(1'b1, PIC_NMI_VEC, PIC_NMI_LVL); // selected edge, unmaskable.
      tick(60);
    end
    results();
  end
endmodule
